/* File: hdl/sepc_pkg.sv */
// Constants and types shared by the serial EEPROM command port
package sepc_pkg;

	// Instruction byte layout and low-bit opcodes
	localparam logic [3:0] OP_HI_ZERO   = 4'h0;
	localparam int         OP_TOP_BIT   = 3;
	localparam logic [2:0] OP_READ      = 3'h3;
	localparam logic [2:0] OP_WRITE     = 3'h2;
	localparam logic [2:0] OP_LCLEAR    = 3'h4;
	localparam logic [2:0] OP_LSET      = 3'h6;
	localparam logic [2:0] OP_SREAD     = 3'h5;
	localparam logic [2:0] OP_SWRITE    = 3'h1;

	// Array geometry
	localparam int         ADDR_W       = 9;
	localparam int         PAGE_W       = 4;
	localparam int         ARRAY_BYTES  = 512;
	localparam int         PAGE_BYTES   = 16;

	// Protection levels and their lowest protected address
	localparam logic [1:0] PROT_NONE    = 2'h0;
	localparam logic [1:0] PROT_QUART   = 2'h1;
	localparam logic [1:0] PROT_HALF    = 2'h2;
	localparam logic [8:0] QUART_BASE   = 9'h180;
	localparam logic [8:0] HALF_BASE    = 9'h100;

	// Status byte field positions
	localparam int         ST_BUSY      = 0;
	localparam int         ST_LATCH     = 1;
	localparam int         ST_PROT_LO   = 2;
	localparam int         ST_PROT_HI   = 3;

	// Timing: self-timed write cycle at a 5 ns clock
	localparam longint     TWC_NS       = 5000000;
	localparam longint     CLK_NS       = 5;
	localparam int         TWC_CYC      = int'(TWC_NS / CLK_NS);

	// APB register byte addresses and fields
	localparam logic [7:0] REG_WTIME    = 8'h00;
	localparam logic [7:0] REG_STATE    = 8'h04;
	localparam int         SV_PAUSED    = 8;
	localparam int         SV_SELECTED  = 9;

	// Sequence states
	typedef enum logic [2:0] {
		SQ_IDLE, SQ_CMD, SQ_ADDR, SQ_RDATA, SQ_WDATA,
		SQ_SREAD, SQ_SWRITE, SQ_WAIT
	} sepc_seq_type;

	// Pin bundle as seen from the link
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} sepc_pins_type;

	localparam sepc_pins_type PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
		hold_n: 1'b1, wp_n: 1'b1};

endpackage

/* File: hdl/sepc_port.sv */
// Serial EEPROM command port: pin logic, sequencer, array, write timer, APB
//
// Overview of operation
// - Deselect idles and floats the serial output
// - Started programming completes despite select changes
// - Select rise after valid write starts programming
// - Sample input on rise, drive output on fall
// - Write-protect low refuses writes, clears latch
// - Write-protect low never aborts running programming
// - Pause takes effect while clock is low
// - Paused sequence ignores clock and data
// - Resume takes effect while clock is low
// - Pause input floats output at once
// - Eight-bit instruction, all fields MSB first
// - Array opcodes carry the top address bit
// - Other opcodes: upper nibble zero, bit3 ignored
// - Array opcode followed by low address byte
// - Reads stream on, address wraps at top
// - Latch set needs select rise after opcode
// - Page write wraps within sixteen-byte page
// - Program only when select rises on boundary
// - Status readable while busy, array ignored
// - Programming completion clears the write latch
// - Status shows busy, latch and protection level
// - Protection level guards upper array ranges
// - Latch cleared by reset, clears, writes, protect
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sepc_port
	import sepc_pkg::*;
#(
	parameter int WRITE_CYCLES = TWC_CYC	// Self-timed write length in pclk cycles
) (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link pins
	input  wire sepc_pins_type pins,
	output logic             so_o,
	output logic             so_oe
);

	// Three-stage pin synchronisers and filtered levels
	sepc_pins_type s1_r, s2_r, s3_r, f_r;
	logic          sck_q_r;		// Previous filtered clock level

	// Sequencer state
	sepc_seq_type  seq_r, seq_nxt;
	logic [2:0]    bit_r;		// Bit index within a byte
	logic [7:0]    shin_r;		// Incoming shift register
	logic [7:0]    cmd_r;		// Held instruction
	logic [7:0]    tx_r;		// Outgoing byte
	logic [8:0]    addr_r;		// Address pointer
	logic          have_byte_r;	// Write stopped on a byte boundary
	logic          paused_r;	// Pause in force
	logic          drive_r;		// Read phase owns the output
	logic          over_r;		// Clocks seen after a finished command byte

	// Array, page buffer and status
	logic [7:0]    mem_r [ARRAY_BYTES];
	logic [7:0]    pbuf_r [PAGE_BYTES];
	logic [15:0]   pmask_r;		// Page slots loaded this write
	logic [8:0]    pbase_r;		// Page of the pending write
	logic          wel_r;		// write_latch_flag
	logic [1:0]    prot_r;		// protect_level_hi/lo
	logic [1:0]    new_prot_r;	// Protection value awaiting commit
	logic          sw_pend_r;	// Pending write targets status
	logic          busy_r;		// write_busy_flag
	logic [31:0]   busy_cnt_r;	// Cycles left of the write
	logic [31:0]   wtime_r;		// Software-set write length

	// APB and serial outputs
	logic [31:0]   prdata_r;
	logic          pready_r, pslverr_r, so_r, so_oe_r;

	// Address inside a protected range
	function automatic logic is_prot(input logic [8:0] a, input logic [1:0] lvl);
		logic p;
		p = 1'b0;
		case (lvl)
			PROT_NONE:  p = 1'b0;
			PROT_QUART: p = (a >= QUART_BASE);
			PROT_HALF:  p = (a >= HALF_BASE);
			default:    p = 1'b1;
		endcase
		return p;
	endfunction

	// Next address inside the current page
	function automatic logic [8:0] page_inc(input logic [8:0] a);
		return {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 4'h1};
	endfunction

	// Edge and condition decode
	wire sel       = ~f_r.cs_n;
	wire act       = sel & ~paused_r & f_r.hold_n;
	wire sck_rise  = act & f_r.sck & ~sck_q_r;
	wire sck_fall  = act & ~f_r.sck & sck_q_r;
	wire [7:0] byte_in = {shin_r[6:0], f_r.si};		// MSB first
	wire byte_end  = sck_rise & (bit_r == 3'h7);
	wire [2:0] op  = byte_in[2:0];
	wire op_ok     = byte_in[7:4] == OP_HI_ZERO;
	wire [7:0] status = {4'h0, prot_r, wel_r, busy_r};
	wire wp_ok     = f_r.wp_n;
	wire deselect  = f_r.cs_n & (seq_r != SQ_IDLE);		// Select just rose
	wire commit_ok = deselect & have_byte_r & wel_r & wp_ok & ~busy_r;
	wire start_prog = commit_ok & ((seq_r == SQ_WDATA) | (seq_r == SQ_SWRITE));
	// Latch commands act only on a valid opcode framed by exactly eight clocks
	wire cmd_end   = deselect & (seq_r == SQ_WAIT) & ~over_r
		& (cmd_r[7:4] == OP_HI_ZERO);
	wire busy_done = busy_r & (busy_cnt_r == 32'h1);
	wire apb_setup = psel & ~penable;
	wire apb_wr    = psel & penable & pready_r & pwrite;
	wire hit_wtime = paddr == REG_WTIME;
	wire hit_state = paddr == REG_STATE;

	// Pin synchronisers: a change counts when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r    <= PINS_IDLE;
			s2_r    <= PINS_IDLE;
			s3_r    <= PINS_IDLE;
			f_r     <= PINS_IDLE;	// Select reads high, so a fall is needed
			sck_q_r <= 1'b0;
		end else begin
			s1_r    <= pins;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			f_r     <= (s2_r == s3_r) ? s3_r : f_r;
			sck_q_r <= f_r.sck;
		end
	end

	// Pause control: enter and leave only while the clock is low; deselect ends it at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			paused_r <= 1'b0;
		end else if (!sel) begin
			paused_r <= 1'b0;
		end else if (!f_r.sck) begin
			paused_r <= ~f_r.hold_n;
		end
	end

	// Sequencer next state
	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			SQ_IDLE: begin
				if (sel) begin
					seq_nxt = SQ_CMD;
				end
			end
			SQ_CMD: begin
				if (byte_end) begin
					if (!op_ok) begin
						seq_nxt = SQ_WAIT;
					end else if (op == OP_READ) begin
						seq_nxt = busy_r ? SQ_WAIT : SQ_ADDR;
					end else if (op == OP_WRITE) begin
						seq_nxt = busy_r ? SQ_WAIT : SQ_ADDR;
					end else if (op == OP_SREAD) begin
						seq_nxt = SQ_SREAD;
					end else if (op == OP_SWRITE) begin
						seq_nxt = SQ_SWRITE;
					end else begin
						seq_nxt = SQ_WAIT;
					end
				end
			end
			SQ_ADDR: begin
				if (byte_end) begin
					seq_nxt = (cmd_r[2:0] == OP_READ) ? SQ_RDATA : SQ_WDATA;
				end
			end
			default: seq_nxt = seq_r;
		endcase
		if (!sel) begin
			seq_nxt = SQ_IDLE;
		end
	end

	// Sequencer registers and shifting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_r <= SQ_IDLE;
			bit_r <= 3'h0;
			shin_r <= 8'h00;
			cmd_r <= 8'h00;
			over_r <= 1'b0;
		end else begin
			seq_r <= seq_nxt;
			over_r <= (!sel) ? 1'b0 : (over_r | (sck_rise & (seq_r == SQ_WAIT)));
			bit_r <= (!sel) ? 3'h0 : (sck_rise ? bit_r + 3'h1 : bit_r);
			shin_r <= sck_rise ? byte_in : shin_r;
			cmd_r <= (byte_end && seq_r == SQ_CMD) ? byte_in : cmd_r;
		end
	end

	// Address pointer, outgoing byte and write-byte tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_r <= 9'h000;
			tx_r <= 8'h00;
			have_byte_r <= 1'b0;
			drive_r <= 1'b0;
		end else if (!sel) begin
			have_byte_r <= 1'b0;
			drive_r <= 1'b0;
		end else if (byte_end && seq_r == SQ_ADDR) begin
			addr_r <= {cmd_r[OP_TOP_BIT], byte_in};
			tx_r <= mem_r[{cmd_r[OP_TOP_BIT], byte_in}];
			drive_r <= cmd_r[2:0] == OP_READ;
		end else if (byte_end && seq_r == SQ_CMD && op_ok && op == OP_SREAD) begin
			tx_r <= status;
			drive_r <= 1'b1;
		end else if (byte_end && seq_r == SQ_RDATA) begin
			addr_r <= addr_r + 9'h001;	// Wraps from top to zero
			tx_r <= mem_r[addr_r + 9'h001];
		end else if (byte_end && seq_r == SQ_SREAD) begin
			tx_r <= status;
		end else if (byte_end && (seq_r == SQ_WDATA || seq_r == SQ_SWRITE)) begin
			addr_r <= (seq_r == SQ_WDATA) ? page_inc(addr_r) : addr_r;
			have_byte_r <= 1'b1;
		end else if (sck_rise) begin
			have_byte_r <= 1'b0;	// Partial byte abandons the write
		end else if (sck_fall && drive_r) begin
			tx_r <= {tx_r[6:0], 1'b0};	// MSB first
		end
	end

	// Serial output: driven after falling clock edges of a read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_r <= (sck_fall && drive_r) ? tx_r[7] : so_r;
			so_oe_r <= sel & f_r.hold_n & drive_r;
		end
	end

	// Page buffer capture during a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pmask_r <= 16'h0000;
			pbase_r <= 9'h000;
			new_prot_r <= 2'h0;
			sw_pend_r <= 1'b0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				pbuf_r[i] <= 8'h00;
			end
		end else if (seq_r == SQ_IDLE && sel) begin
			pmask_r <= 16'h0000;
		end else if (byte_end && seq_r == SQ_WDATA) begin
			pbuf_r[addr_r[PAGE_W-1:0]] <= byte_in;	// Overwrites on wrap
			pmask_r[addr_r[PAGE_W-1:0]] <= 1'b1;
			pbase_r <= addr_r;
			sw_pend_r <= 1'b0;
		end else if (byte_end && seq_r == SQ_SWRITE) begin
			new_prot_r <= {byte_in[ST_PROT_HI], byte_in[ST_PROT_LO]};
			sw_pend_r <= 1'b1;
		end
	end

	// Array update at the start of programming, protected bytes skipped
	always_ff @(posedge pclk) begin
		for (int i = 0; i < PAGE_BYTES; i++) begin
			if (start_prog && !sw_pend_r && pmask_r[i]
				&& !is_prot({pbase_r[ADDR_W-1:PAGE_W], 4'(i)}, prot_r)) begin
				mem_r[{pbase_r[ADDR_W-1:PAGE_W], 4'(i)}] <= pbuf_r[i];
			end
		end
	end

	// Write timer: runs to the end regardless of select or protect pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
			busy_cnt_r <= 32'h0;
			prot_r <= PROT_NONE;
		end else if (start_prog) begin
			busy_r <= 1'b1;
			busy_cnt_r <= (wtime_r == 32'h0) ? 32'h1 : wtime_r;
			prot_r <= sw_pend_r ? new_prot_r : prot_r;
		end else if (busy_r) begin
			busy_r <= ~busy_done;
			busy_cnt_r <= busy_cnt_r - 32'h1;
		end
	end

	// Write enable latch: a set in the same cycle as a clear wins
	// Kept set while busy unless protect drops or a latch clear arrives, so status shows it; completion clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wel_r <= 1'b0;
		end else if (cmd_end && cmd_r[2:0] == OP_LSET && wp_ok) begin
			wel_r <= 1'b1;
		end else if (!wp_ok || busy_done) begin
			wel_r <= 1'b0;
		end else if (cmd_end && cmd_r[2:0] == OP_LCLEAR) begin
			wel_r <= 1'b0;
		end
	end

	// APB slave: zero wait states, error on unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wtime_r <= 32'(WRITE_CYCLES);
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= apb_setup;
			pslverr_r <= apb_setup & ~hit_wtime & ~hit_state;
			prdata_r <= ~(apb_setup & ~pwrite) ? 32'h0 : hit_wtime ? wtime_r
				: hit_state ? {22'h0, sel, paused_r, status} : 32'h0;
			wtime_r <= (apb_wr && hit_wtime) ? pwdata : wtime_r;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign so_o    = so_r;
	assign so_oe   = so_oe_r;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_valid_commit;
		deselect && (seq_r == SQ_WDATA) && have_byte_r && wel_r && wp_ok && !busy_r;
	endsequence

	a_standby_float: assert property (!sel |=> !so_oe) else $error("output driven deselected");
	a_prog_runs: assert property (busy_r && busy_cnt_r > 32'h1 |=> busy_r) else $error("write aborted");
	a_commit_start: assert property (s_valid_commit |=> busy_r) else $error("write not started");
	a_wp_clear: assert property (!wp_ok |=> !wel_r) else $error("latch kept under protect");
	a_pause_freeze: assert property (paused_r |=> $stable(bit_r) && $stable(shin_r)) else $error("paused moved");
	a_hold_float: assert property (!f_r.hold_n |=> !so_oe) else $error("output driven in pause");
	a_done_clear: assert property ($fell(busy_r) |-> !wel_r) else $error("latch after write");
	a_nolatch_nostart: assert property (!wel_r |=> !$rose(busy_r)) else $error("write without latch");
	a_busy_ignore: assert property (busy_r && byte_end && seq_r == SQ_CMD && op_ok
		&& op == OP_READ |=> seq_r != SQ_ADDR) else $error("array reached while busy");
	a_stray_noset: assert property (deselect && over_r && !wel_r |=> !wel_r)
		else $error("latch set by long frame");

	sequence s_top_read_byte;
		byte_end && (seq_r == SQ_RDATA) && (addr_r == 9'(ARRAY_BYTES - 1));
	endsequence
	a_read_wrap: assert property (s_top_read_byte |=> addr_r == 9'h000)
		else $error("read address did not wrap");
	a_page_wrap: assert property (byte_end && seq_r == SQ_WDATA
		&& addr_r[PAGE_W-1:0] == 4'hf |=> $stable(addr_r[ADDR_W-1:PAGE_W])
		&& addr_r[PAGE_W-1:0] == 4'h0) else $error("page pointer left page");

endmodule // sepc_port

`default_nettype wire

/* File: test/sepc_host.sv */
// Behavioural SPI host that drives the serial pins of the command port
`timescale 1ns/1ps
`default_nettype none

module sepc_host
	import sepc_pkg::*;
(
	// Pacing clock
	input  wire logic          pclk,
	// Serial pins toward the port
	output var sepc_pins_type  pins,
	input  wire logic          so_o,
	input  wire logic          so_oe
);
	// Deselected, clock low, not paused at power-up
	initial pins = PINS_IDLE;

	// Wait whole pclk cycles
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Drive the write-protect pin
	task automatic wp(input logic v);
		pins.wp_n <= v;
	endtask

	// Select the port, then wait eight pclk cycles
	task automatic sel();
		pins.cs_n <= 1'b0;
		tick(8);
	endtask

	// Deselect after whole bytes; the released data line shows its inverse
	task automatic desel();
		tick(8);
		pins.cs_n <= 1'b1;
		pins.si   <= ~pins.si;
		tick(8);
	endtask

	// Shift n bits, top first: drive while sck is low, sample on the rise
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = n - 1; i >= 0; i--) begin
			pins.si <= tx[i];
			tick(8);
			pins.sck <= 1'b1;
			rx[i] = so_o;
			tick(8);
			pins.sck <= 1'b0;
		end
	endtask

	// Pause with sck low, wiggle the ignored pins, resume with sck low
	task automatic pause(output logic oe_seen);
		tick(4);
		pins.hold_n <= 1'b0;
		tick(8);
		oe_seen = so_oe;
		repeat (2) begin
			pins.sck <= ~pins.sck;
			pins.si  <= ~pins.si;
			tick(8);
		end
		pins.hold_n <= 1'b1;
		tick(8);
	endtask
endmodule // sepc_host

`default_nettype wire

/* File: test/spi_eeprom_command_port_tb.sv */
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_command_port_tb
	import sepc_pkg::*;
;
	localparam int WT = 2000;	// Shortened write cycle, pclk cycles

	logic          pclk = 1'b0;	// 200 MHz clock
	logic          presetn = 1'b0;	// Active-low reset
	logic          psel = 1'b0;	// APB request
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata;	// APB answer
	logic          pready;
	logic          pslverr;
	sepc_pins_type pins;	// Link pins from the host
	logic          so_o;	// Serial data out
	logic          so_oe;
	int            bad_count = 0;	// Mismatches
	int            checks = 0;	// Comparisons
	int            cyc = 0;	// Cycles run
	logic [31:0]   q;	// Scratch values
	logic          e;
	logic [7:0]    s;
	logic [7:0]    b1;
	logic [7:0]    b2;
	logic [7:0]    r[$];
	logic [7:0]    codes[4] = '{8'h0e, 8'h0c, 8'h86, 8'h06};	// Latch codes
	logic [7:0]    lat[4] = '{8'h02, 8'h00, 8'h00, 8'h02};	// Status after each

	sepc_port #(.WRITE_CYCLES(WT)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(pins), .so_o(so_o), .so_oe(so_oe));
	sepc_host host (.pclk(pclk), .pins(pins), .so_o(so_o), .so_oe(so_oe));

	// Free-running clock
	always #2.5 pclk = ~pclk;

	// Cut a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			stop_test();
		end
	end

	// Count and report a comparison
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One APB transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic er);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rq = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Instruction byte
	function automatic logic [7:0] op(input logic a8, input logic [2:0] lo);
		return {OP_HI_ZERO, a8, lo};
	endfunction

	// One selected frame of whole bytes
	task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
		logic [7:0] v;
		rx = {};
		host.sel();
		foreach (tx[i]) begin
			host.shift(tx[i], 8, v);
			rx.push_back(v);
		end
		host.desel();
	endtask

	// Status byte over the link, ignored bit set
	task automatic stat(output logic [7:0] st);
		logic [7:0] x[$];
		frame({op(1'b1, OP_SREAD), 8'h00}, x);
		st = x[1];
	endtask

	// Poll the busy flag until it clears
	task automatic idle();
		logic [7:0] st;
		st = 8'h01;
		for (int k = 0; k < 20 && st[ST_BUSY]; k++) begin
			stat(st);
		end
		check(st[ST_BUSY], 1'b0);
	endtask

	// Latch set, write frame, status while busy, then wait it out
	task automatic prog(input logic [7:0] tx[$], input logic [7:0] bst, input logic wpl);
		logic [7:0] st;
		frame({op(1'b0, OP_LSET)}, r);
		frame(tx, r);
		stat(st);
		check(st, bst);
		host.sel();
		host.shift(op(1'b0, OP_READ), 8, st);
		host.shift(8'h00, 8, st);
		host.shift(8'h00, 8, st);
		check(so_oe, 1'b0);
		host.desel();
		host.wp(~wpl);
		idle();
		host.wp(1'b1);
		stat(st);
		check(st, bst & 8'h0c);
	endtask

	// Stream bytes from an address and compare each
	task automatic rd(input logic [8:0] a, input logic [7:0] exp[$]);
		logic [7:0] tx[$];
		tx = {op(a[8], OP_READ), a[7:0]};
		foreach (exp[i])
			tx.push_back(8'h00);
		frame(tx, r);
		foreach (exp[i])
			check(r[i + 2], exp[i]);
	endtask

	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(so_oe, 1'b0);
		apb(1'b0, REG_WTIME, 32'h0, q, e);
		check(q, 32'(WT));
		apb(1'b1, REG_STATE, 32'hffff_ffff, q, e);
		check(e, 1'b0);
		apb(1'b0, REG_STATE, 32'h0, q, e);
		check(q, 32'h0);
		apb(1'b0, 8'h08, 32'h0, q, e);
		check(e, 1'b1);
		host.sel();
		host.desel();
		foreach (codes[i]) begin
			frame({codes[i]}, r);
			stat(s);
			check(s, lat[i]);
		end
		frame({op(1'b0, OP_LCLEAR)}, r);
		frame({op(1'b0, OP_LSET), op(1'b0, OP_WRITE), 8'h20, 8'h77}, r);
		stat(s);
		check(s, 8'h00);
		frame({op(1'b0, OP_LSET)}, r);
		host.sel();
		host.shift(op(1'b0, OP_WRITE), 8, b1);
		host.shift(8'h20, 8, b1);
		host.shift(8'h77, 8, b1);
		host.shift(8'h0f, 4, b1);
		host.desel();
		stat(s);
		check(s, 8'h02);
		prog({op(1'b0, OP_WRITE), 8'h00, 8'h5a}, 8'h03, 1'b0);
		prog({op(1'b1, OP_WRITE), 8'hfe, 8'ha1, 8'ha2, 8'ha3}, 8'h03, 1'b1);
		rd(9'h1ff, {8'ha2, 8'h5a});
		rd(9'h1f0, {8'ha3});
		host.sel();
		host.shift(op(1'b1, OP_READ), 8, b1);
		host.shift(8'hfe, 8, b1);
		host.shift(8'h00, 3, b1);
		host.pause(e);
		check(e, 1'b0);
		check(so_oe, 1'b1);
		host.shift(8'h00, 5, b2);
		host.desel();
		check({b1[2:0], b2[4:0]}, 8'ha1);
		check(so_oe, 1'b0);
		host.wp(1'b0);
		frame({op(1'b0, OP_LSET)}, r);
		stat(s);
		check(s, 8'h00);
		host.wp(1'b1);
		prog({op(1'b1, OP_SWRITE), 8'h04}, 8'h07, 1'b0);
		frame({op(1'b0, OP_LSET)}, r);
		frame({op(1'b1, OP_WRITE), 8'hf0, 8'h11}, r);
		idle();
		rd(9'h1f0, {8'ha3});
		stop_test();
	end
endmodule // spi_eeprom_command_port_tb

`default_nettype wire
